//--- tdes_card_model.sv
`timescale 1ns/100ps
// receive side of the rf link: counts envelope-high cycles in a window
// measured from the first envelope cycle of each frame
module tdes_card_model #(
  parameter int WIN_LO = 293,
  parameter int WIN_HI = 2629
) (
  input  wire logic        clk,       // system clock
  input  wire logic        tx_env,    // envelope from encoder
  input  wire logic        tx_active, // frame in progress
  output logic      [15:0] hi_cnt,    // high cycles in window
  output logic      [15:0] frames     // frames seen
);
  logic     act_q = 1'b0;
  int       idx   = 0;
  initial begin
    hi_cnt = 16'h0000;
    frames = 16'h0000;
  end
  always @(posedge clk) begin
    act_q <= tx_active;
    if (tx_active && !act_q) begin
      idx    <= 1;
      hi_cnt <= 16'h0000;
      frames <= frames + 16'h0001;
    end else begin
      idx <= idx + 1;
      if (idx >= WIN_LO && idx < WIN_HI && tx_env === 1'b1) begin
        hi_cnt <= hi_cnt + 16'h0001;
      end
    end
  end
endmodule // tdes_card_model

//--- tdes_encoder.sv
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
module tdes_encoder import tdes_pkg::*; (
  input  wire logic        CLK,       // system clock, 250 MHz
  input  wire logic        NRST,      // synchronous reset, active low
  input  wire logic        HSEL,      // slave select
  input  wire logic [31:0] HADDR,     // byte address
  input  wire logic [1:0]  HTRANS,    // transfer type
  input  wire logic        HWRITE,    // write transfer
  input  wire logic [2:0]  HSIZE,     // transfer size
  input  wire logic [31:0] HWDATA,    // write data
  input  wire logic        HREADY,    // bus ready
  output logic      [31:0] HRDATA,    // read data
  output logic             HREADYOUT, // slave ready
  output logic             HRESP,     // response, always okay
  output logic             TX_ENV,    // encoded envelope to transmitter
  output logic             TX_ACTIVE  // frame in progress
);
  typedef struct packed {
    tdes_state_e   st;
    logic [7:0]    cfg_mod;
    logic [7:0]    cfg_freq;
    logic [7:0]    sym0_hi;
    logic [7:0]    sym0_lo;
    logic [7:0]    sym1_hi;
    logic [7:0]    sym1_lo;
    logic [7:0]    sym2;
    logic [7:0]    sym_len;
    logic [7:0]    snap_mod;
    logic [7:0]    snap_freq;
    logic [7:0]    snap_len;
    logic [15:0]   snap_sym1;
    logic [7:0]    snap_sym2;
    logic [QUEUE_AW-1:0] wr_ptr;
    logic [QUEUE_AW-1:0] rd_ptr;
    logic [3:0]    count;
    logic          a_valid;
    logic          a_write;
    logic [7:0]    a_idx;
    logic [31:0]   hrdata;
    logic [11:0]   qcnt;
    logic [11:0]   qlen;
    logic [1:0]    quarter;
    logic [3:0]    bit_idx;
    logic [15:0]   shreg;
    logic          bit_start;
    logic [8:0]    sc_cnt;
    logic          sc;
    logic          active;
  } tdes_enc_s;

  tdes_enc_s r;
  tdes_enc_s next_r;
  logic       push;
  logic       pop;
  logic       start;
  logic       tick;
  logic       bit_end;
  logic       seg_end;
  logic       launch;
  logic       sc_sel;
  logic [8:0] sc_half;
  logic [7:0] mem_rdata;

  // quarter-bit length in cycles for a bit-rate code
  function automatic logic [11:0] rate_qtr(input logic [2:0] code);
    if (code < RATE_MIN_CODE) begin
      rate_qtr = QTR_26K; // reserved codes fall back to the slowest rate
    end else begin
      rate_qtr = QTR_26K >> (code - RATE_MIN_CODE);
    end
  endfunction

  // left-align a pattern of len+1 valid bits, sent msb first
  function automatic logic [15:0] align_pat(input logic [15:0] pat,
                                            input logic [3:0]  len);
    align_pat = pat << (PAT_LAST - len);
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7-i];
    end
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] idx);
    read_reg = 8'h00;
    case (idx)
      IDX_DATA_MOD: read_reg = r.cfg_mod;
      IDX_SYM_FREQ: read_reg = r.cfg_freq;
      IDX_SYM0_HI:  read_reg = r.sym0_hi;
      IDX_SYM0_LO:  read_reg = r.sym0_lo;
      IDX_SYM1_HI:  read_reg = r.sym1_hi;
      IDX_SYM1_LO:  read_reg = r.sym1_lo;
      IDX_SYM2:     read_reg = r.sym2;
      IDX_SYM_LEN:  read_reg = r.sym_len;
      IDX_STATUS: begin
        read_reg[STAT_BUSY]  = (r.st != ST_IDLE);
        read_reg[STAT_FULL]  = (r.count == QUEUE_DEPTH);
        read_reg[STAT_EMPTY] = (r.count == 4'h0);
        read_reg[STAT_COUNT_LSB+:4] = r.count;
      end
      default: read_reg = 8'h00;
    endcase
  endfunction

  assign tick    = (r.qcnt == r.qlen - 12'h001);
  assign bit_end = tick && (r.quarter == 2'h3);
  assign seg_end = bit_end && (r.bit_idx == 4'h0);
  assign push    = r.a_valid && r.a_write && (r.a_idx == IDX_QUEUE)
                   && (r.count != QUEUE_DEPTH);
  assign start   = r.a_valid && r.a_write && (r.a_idx == IDX_CTRL)
                   && HWDATA[CTRL_START];
  assign launch  = (r.st == ST_RETRIG)
                   || (r.st == ST_IDLE && start && r.count != 4'h0);
  // the subcarrier only reaches the output through envelopes 2 and 3
  assign sc_sel  = (r.st == ST_TRAIL) ? r.snap_freq[FREQ_HI_SC]
                                      : r.snap_freq[FREQ_LO_SC];
  assign sc_half = sc_sel ? SC848_HALF : SC424_HALF;

  always_comb begin
    next_r = r;
    pop = 1'b0;
    next_r.bit_start = 1'b0;

    // address phase; zero wait states, read data prepared here
    next_r.a_valid = HSEL && HTRANS[1] && HREADY && HSIZE == 3'b010
                     && HADDR[1:0] == 2'b00 && HADDR[31:10] == 22'h0;
    next_r.a_write = HWRITE;
    next_r.a_idx   = HADDR[9:2];
    if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
      next_r.hrdata = {24'h000000, read_reg(HADDR[9:2])};
      if (!next_r.a_valid) begin
        next_r.hrdata = 32'h00000000;
      end
    end

    // data phase writes; changes reach the stream at the next start
    if (r.a_valid && r.a_write) begin
      case (r.a_idx)
        IDX_DATA_MOD: next_r.cfg_mod  = HWDATA[7:0];
        IDX_SYM_FREQ: next_r.cfg_freq = HWDATA[7:0];
        IDX_SYM0_HI:  next_r.sym0_hi  = HWDATA[7:0];
        IDX_SYM0_LO:  next_r.sym0_lo  = HWDATA[7:0];
        IDX_SYM1_HI:  next_r.sym1_hi  = HWDATA[7:0];
        IDX_SYM1_LO:  next_r.sym1_lo  = HWDATA[7:0];
        IDX_SYM2:     next_r.sym2     = HWDATA[7:0];
        IDX_SYM_LEN:  next_r.sym_len  = HWDATA[7:0];
        default: ;
      endcase
    end

    // bit timing: four quarters of qlen cycles each
    if (r.active) begin
      next_r.qcnt = tick ? 12'h000 : r.qcnt + 12'h001;
      if (tick) begin
        next_r.quarter = r.quarter + 2'h1;
      end
      if (bit_end) begin
        next_r.bit_start = 1'b1;
        next_r.shreg     = {r.shreg[14:0], 1'b0};
        next_r.bit_idx   = r.bit_idx - 4'h1;
      end
    end

    if (seg_end) begin
      case (r.st)
        ST_SOF: begin
          next_r.st      = ST_DATA;
          next_r.shreg   = {rev8(mem_rdata), 8'h00};
          next_r.bit_idx = BYTE_LAST;
          pop = 1'b1;
        end
        ST_DATA: begin
          if (r.snap_mod[MOD_FRAME_STEP] || r.count == 4'h0) begin
            next_r.st      = ST_EOF;
            next_r.shreg   = align_pat(r.snap_sym1,
                                       r.snap_len[LEN_SYM1_LSB+:4]);
            next_r.bit_idx = r.snap_len[LEN_SYM1_LSB+:4];
          end else begin
            // whole queue goes out inside one frame
            next_r.shreg   = {rev8(mem_rdata), 8'h00};
            next_r.bit_idx = BYTE_LAST;
            pop = 1'b1;
          end
        end
        ST_EOF: begin
          next_r.st      = ST_TRAIL;
          next_r.shreg   = {r.snap_sym2, 8'h00};
          next_r.bit_idx = BYTE_LAST;
          next_r.qlen    = rate_qtr(r.snap_freq[FREQ_HI_RATE+:3]);
        end
        ST_TRAIL: begin
          next_r.st = (r.snap_mod[MOD_FRAME_STEP] && r.count != 4'h0)
                      ? ST_RETRIG : ST_IDLE;
        end
        default: next_r.st = ST_IDLE;
      endcase
    end

    // start: by software, or by the automatic retrigger in frame step
    if (launch) begin
      next_r.st        = ST_SOF;
      next_r.snap_mod  = r.cfg_mod;
      next_r.snap_freq = r.cfg_freq;
      next_r.snap_len  = r.sym_len;
      next_r.snap_sym1 = {r.sym1_hi, r.sym1_lo};
      next_r.snap_sym2 = r.sym2;
      next_r.shreg     = align_pat({r.sym0_hi, r.sym0_lo},
                                   r.sym_len[LEN_SYM0_LSB+:4]);
      next_r.bit_idx   = r.sym_len[LEN_SYM0_LSB+:4];
      next_r.qlen      = rate_qtr(r.cfg_freq[FREQ_LO_RATE+:3]);
      next_r.qcnt      = 12'h000;
      next_r.quarter   = 2'h0;
      next_r.bit_start = 1'b1;
    end

    // queue bookkeeping; flush only while idle
    if (push) begin
      next_r.wr_ptr = r.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_r.rd_ptr = r.rd_ptr + 1'b1;
    end
    next_r.count = r.count + {3'h0, push} - {3'h0, pop};
    if (r.a_valid && r.a_write && r.a_idx == IDX_CTRL
        && HWDATA[CTRL_FLUSH] && r.st == ST_IDLE) begin
      next_r.wr_ptr = '0;
      next_r.rd_ptr = '0;
      next_r.count  = 4'h0;
    end

    next_r.active = (next_r.st != ST_IDLE) && (next_r.st != ST_RETRIG);

    // subcarrier runs only inside a frame so its phase starts fresh
    if (!r.active) begin
      next_r.sc_cnt = 9'h000;
      next_r.sc     = 1'b0;
    end else if (r.sc_cnt >= sc_half - 9'h001) begin
      next_r.sc_cnt = 9'h000;
      next_r.sc     = ~r.sc;
    end else begin
      next_r.sc_cnt = r.sc_cnt + 9'h001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      r <= '0;
      r.cfg_mod  <= RST_DATA_MOD;
      r.cfg_freq <= RST_SYM_FREQ;
      r.sym0_hi  <= RST_PATTERN;
      r.sym0_lo  <= RST_PATTERN;
      r.sym1_hi  <= RST_PATTERN;
      r.sym1_lo  <= RST_PATTERN;
      r.sym2     <= RST_PATTERN;
      r.sym_len  <= RST_SYM_LEN;
      r.qlen     <= QTR_26K;
    end else begin
      r <= next_r;
    end
  end

  tdes_queue_mem u_mem (
    .clk   (CLK),
    .we    (push),
    .waddr (r.wr_ptr),
    .wdata (HWDATA[7:0]),
    .raddr (r.rd_ptr),
    .rdata (mem_rdata)
  );

  tdes_shaper u_shaper (
    .clk       (CLK),
    .nrst      (NRST),
    .active    (r.active),
    .bit_in    (r.shreg[15]),
    .bit_start (r.bit_start),
    .quarter   (r.quarter),
    .sc        (r.sc),
    .mode      (r.snap_mod),
    .env_out   (TX_ENV)
  );

  // the bus answers every transfer at once with okay
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  assign HRDATA    = r.hrdata;
  assign TX_ACTIVE = r.active;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_single_frame_start;
    r.st == ST_IDLE && start && r.count != 4'h0
      |=> r.st == ST_SOF && r.snap_mod == $past(r.cfg_mod);
  endproperty
  a_single_frame_start: assert property (p_single_frame_start)
    else $error("start did not open a frame with the current settings");

  property p_step_closes;
    r.st == ST_DATA && seg_end && r.snap_mod[MOD_FRAME_STEP]
      |=> r.st == ST_EOF;
  endproperty
  a_step_closes: assert property (p_step_closes)
    else $error("frame step byte not followed by end of frame");

  property p_stream_continues;
    r.st == ST_DATA && seg_end && !r.snap_mod[MOD_FRAME_STEP]
      && r.count != 4'h0 |=> r.st == ST_DATA && r.bit_idx == BYTE_LAST;
  endproperty
  a_stream_continues: assert property (p_stream_continues)
    else $error("queued byte not sent in the same frame");

  property p_retrigger;
    r.st == ST_RETRIG |=> r.st == ST_SOF ##1 r.active [*2];
  endproperty
  a_retrigger: assert property (p_retrigger)
    else $error("automatic retrigger did not restart the frame");

  property p_low_rate_top;
    launch && r.cfg_freq[FREQ_LO_RATE+:3] == 3'b111
      |=> r.qlen == (QTR_26K >> 5);
  endproperty
  a_low_rate_top: assert property (p_low_rate_top)
    else $error("low pair code 7 not at 848 kHz");

  property p_high_rate_top;
    r.st == ST_EOF && seg_end && r.snap_freq[FREQ_HI_RATE+:3] == 3'b111
      |=> r.qlen == (QTR_26K >> 5);
  endproperty
  a_high_rate_top: assert property (p_high_rate_top)
    else $error("high pair code 7 not at 848 kHz");

  property p_sym0_full;
    launch && r.sym_len[LEN_SYM0_LSB+:4] == PAT_LAST
      |=> r.shreg == {$past(r.sym0_hi), $past(r.sym0_lo)};
  endproperty
  a_sym0_full: assert property (p_sym0_full)
    else $error("symbol 0 pattern not high byte first");

  property p_sym2_store;
    r.a_valid && r.a_write && r.a_idx == IDX_SYM2
      |=> r.sym2 == $past(HWDATA[7:0]);
  endproperty
  a_sym2_store: assert property (p_sym2_store)
    else $error("symbol 2 write not stored");
endmodule // tdes_encoder

//--- tdes_encoder_tb.sv
`timescale 1ns/100ps
module tdes_encoder_tb import tdes_pkg::*;;
  logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic        tx_env, tx_active;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [15:0] hi_cnt, frames, f0;
  int          n_fail = 0, compares = 0, cyc = 0;

  tdes_encoder u_tdes_encoder (.CLK(clk), .NRST(nrst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .TX_ENV(tx_env),
    .TX_ACTIVE(tx_active));
  // data window: one 848 kHz sof bit (292 cycles), then 8 data bits
  tdes_card_model #(.WIN_LO(293), .WIN_HI(2629)) u_tdes_card_model (
    .clk(clk), .tx_env(tx_env), .tx_active(tx_active), .hi_cnt(hi_cnt),
    .frames(frames));

  always #2 clk = ~clk;
  // fifteen frames of some 5300 to 12000 cycles: about 86000 in all
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_idle();
    int q;
    q = 0;
    repeat (4) @(posedge clk);
    while (q < 4) begin
      @(posedge clk);
      q = (tx_active === 1'b0) ? q + 1 : 0;
    end
  endtask

  task automatic regs();
    xfer(0, IDX_DATA_MOD, 0); check(rd, {24'h0, RST_DATA_MOD});
    xfer(0, IDX_SYM_LEN, 0); check(rd, {24'h0, RST_SYM_LEN});
    for (int i = 8'h4d; i <= 8'h51; i++) begin
      xfer(1, 8'(i), 32'hffffff00 | 32'(8'(i) ^ 8'ha5));
      xfer(0, 8'(i), 0); check(rd, 32'(8'(i) ^ 8'ha5));
      xfer(1, 8'(i), 0);
    end
    xfer(1, 8'h40, 32'h5a); xfer(0, 8'h40, 0); check(rd, 0);
    xfer(1, IDX_SYM_FREQ, 32'h77);
    xfer(0, IDX_SYM_FREQ, 0); check(rd, 32'h77);
    xfer(1, IDX_QUEUE, 32'h11); xfer(1, IDX_QUEUE, 32'h22);
    xfer(0, IDX_STATUS, 0); check(rd, 32'h20);
    xfer(1, IDX_CTRL, 32'h2);
    xfer(0, IDX_STATUS, 0); check(rd, 32'h04);
    check({30'h0, hreadyout, hresp}, 32'h2);
    xfer(1, IDX_SYM_LEN, 0);
  endtask

  // symbols are all zero, so only the data byte can light the window
  task automatic env_run(input logic [7:0] md, dat, output logic [15:0] n);
    xfer(1, IDX_DATA_MOD, {24'h0, md});
    xfer(1, IDX_QUEUE, {24'h0, dat});
    xfer(1, IDX_CTRL, 32'h1);
    wait_idle();
    n = hi_cnt;
  endtask

  task automatic frames_run(input logic [7:0] md, input logic [15:0] exp);
    f0 = frames;
    xfer(1, IDX_DATA_MOD, {24'h0, md});
    xfer(1, IDX_QUEUE, 0);
    xfer(1, IDX_QUEUE, 0);
    xfer(1, IDX_CTRL, 32'h1);
    wait_idle();
    check(32'(frames - f0), 32'(exp));
  endtask

  initial begin
    logic [15:0] n;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    regs();
    env_run(8'h00, 8'hff, n); check(32'(n), 2336);
    env_run(8'h01, 8'hff, n); check(32'(n), 1168);
    env_run(8'h04, 8'hff, n); check(32'(n), 1168);
    env_run(8'h05, 8'hff, n); check(32'(n), 1168);
    env_run(8'h06, 8'hff, n); check(32'(n), 0);
    env_run(8'h08, 8'h00, n); check(32'(n), 2336);
    env_run(8'h0d, 8'hff, n); check(32'(n), 1168);
    env_run(8'h10, 8'hff, n); check(32'(n), 1752);
    env_run(8'h20, 8'hff, n); check(32'(n), 1752);
    env_run(8'h30, 8'hff, n); check(32'(n), 1752);
    // miller is only legal together with pulse type one
    env_run(8'h50, 8'hff, n); check(32'(n), 1752);
    xfer(1, IDX_SYM_FREQ, 32'hff);
    env_run(8'h00, 8'hff, n); check(32'(n), 2336);
    frames_run(8'h80, 16'h2);
    // a full 16-bit symbol 0 opens the last frame
    xfer(1, IDX_SYM0_HI, 32'hc3); xfer(1, IDX_SYM0_LO, 32'h5a);
    xfer(1, IDX_SYM_LEN, 32'h0f);
    frames_run(8'h00, 16'h1);
    close_out();
  end
endmodule // tdes_encoder_tb

//--- tdes_pkg.sv
package tdes_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA_MOD = 8'h4b;
  localparam logic [7:0] IDX_SYM_FREQ = 8'h4c;
  localparam logic [7:0] IDX_SYM0_HI  = 8'h4d;
  localparam logic [7:0] IDX_SYM0_LO  = 8'h4e;
  localparam logic [7:0] IDX_SYM1_HI  = 8'h4f;
  localparam logic [7:0] IDX_SYM1_LO  = 8'h50;
  localparam logic [7:0] IDX_SYM2     = 8'h51;
  localparam logic [7:0] IDX_SYM_LEN  = 8'h53;
  localparam logic [7:0] IDX_CTRL     = 8'h58;
  localparam logic [7:0] IDX_QUEUE    = 8'h59;
  localparam logic [7:0] IDX_STATUS   = 8'h5a;

  // field positions
  localparam int MOD_FRAME_STEP = 7;
  localparam int MOD_MILLER     = 6;
  localparam int MOD_PULSE_LSB  = 4;
  localparam int MOD_INVERT     = 3;
  localparam int MOD_ENV_LSB    = 0;
  localparam int FREQ_HI_SC     = 7;
  localparam int FREQ_HI_RATE   = 4;
  localparam int FREQ_LO_SC     = 3;
  localparam int FREQ_LO_RATE   = 0;
  localparam int LEN_SYM0_LSB   = 0;
  localparam int LEN_SYM1_LSB   = 4;
  localparam int CTRL_START     = 0;
  localparam int CTRL_FLUSH     = 1;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_FULL      = 1;
  localparam int STAT_EMPTY     = 2;
  localparam int STAT_COUNT_LSB = 4;

  // values after reset
  localparam logic [7:0] RST_DATA_MOD = 8'h00;
  localparam logic [7:0] RST_SYM_FREQ = 8'h00;
  localparam logic [7:0] RST_PATTERN  = 8'h00;
  localparam logic [7:0] RST_SYM_LEN  = 8'hff;

  // envelope and pulse codes
  localparam logic [2:0] ENV_DIRECT    = 3'h0;
  localparam logic [2:0] ENV_MANCH     = 3'h1;
  localparam logic [2:0] ENV_MANCH_SC  = 3'h2;
  localparam logic [2:0] ENV_BPSK      = 3'h3;
  localparam logic [2:0] ENV_RZ_SECOND = 3'h4;
  localparam logic [2:0] ENV_RZ_FIRST  = 3'h5;
  localparam logic [1:0] PULSE_NONE    = 2'h0;
  localparam logic [1:0] PULSE_START   = 2'h1;
  localparam logic [1:0] PULSE_HALF    = 2'h2;
  localparam logic [1:0] PULSE_QUARTER = 2'h3;
  localparam logic [2:0] RATE_MIN_CODE = 3'h2;

  // timing, derived from the 13.56 MHz carrier and the 250 MHz clock
  localparam longint CLK_HZ     = 250_000_000;
  localparam longint CARRIER_HZ = 13_560_000;
  localparam longint BIT_DIV_26K = 512;
  localparam longint SC_DIV_424K = 32;
  localparam logic [11:0] QTR_26K =
    12'((CLK_HZ * BIT_DIV_26K) / (CARRIER_HZ * 4));
  localparam logic [8:0] SC424_HALF =
    9'((CLK_HZ * SC_DIV_424K) / (CARRIER_HZ * 2));
  localparam logic [8:0] SC848_HALF = SC424_HALF >> 1;

  localparam int QUEUE_AW = 3;
  localparam logic [3:0] QUEUE_DEPTH = 4'h8;
  localparam logic [3:0] BYTE_LAST   = 4'h7;
  localparam logic [3:0] PAT_LAST    = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SOF    = 3'b001,
    ST_DATA   = 3'b010,
    ST_EOF    = 3'b011,
    ST_TRAIL  = 3'b100,
    ST_RETRIG = 3'b101
  } tdes_state_e;

endpackage

//--- tdes_queue_mem.sv
`timescale 1ns/100ps
module tdes_queue_mem import tdes_pkg::*; (
  input  wire logic                clk,   // system clock
  input  wire logic                we,    // write strobe
  input  wire logic [QUEUE_AW-1:0] waddr, // write address
  input  wire logic [7:0]          wdata, // write byte
  input  wire logic [QUEUE_AW-1:0] raddr, // read address
  output logic      [7:0]          rdata  // registered read byte
);
  typedef struct packed {
    logic [(1<<QUEUE_AW)-1:0][7:0] mem;
    logic [7:0]                    rdata;
  } tdes_mem_s;

  tdes_mem_s r;
  tdes_mem_s next_r;

  always_comb begin
    next_r = r;
    next_r.rdata = r.mem[raddr];
    if (we) begin
      next_r.mem[waddr] = wdata;
    end
  end

  // no reset: contents are only read after being written
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign rdata = r.rdata;
endmodule // tdes_queue_mem

//--- tdes_shaper.sv
`timescale 1ns/100ps
module tdes_shaper import tdes_pkg::*; (
  input  wire logic       clk,       // system clock
  input  wire logic       nrst,      // synchronous reset, active low
  input  wire logic       active,    // frame in progress
  input  wire logic       bit_in,    // pseudo bit
  input  wire logic       bit_start, // first cycle of a bit
  input  wire logic [1:0] quarter,   // quarter of the bit
  input  wire logic       sc,        // subcarrier level
  input  wire logic [7:0] mode,      // snapshot of data modulation
  output logic            env_out    // shaped envelope
);
  typedef struct packed {
    logic last;
    logic prev;
    logic out;
  } tdes_shp_s;

  tdes_shp_s r;
  tdes_shp_s next_r;
  logic [2:0] env;
  logic [1:0] ptype;
  logic       shaped;
  logic       pulse;
  logic       manch;

  assign env   = mode[MOD_ENV_LSB+:3];
  assign ptype = mode[MOD_PULSE_LSB+:2];
  assign manch = (quarter < 2'h2) ? bit_in : ~bit_in;

  always_comb begin
    next_r = r;
    shaped = 1'b0;
    pulse  = 1'b0;
    next_r.last = bit_in;
    if (bit_start) begin
      next_r.prev = r.last;
    end
    case (env)
      ENV_DIRECT:    shaped = bit_in;
      ENV_MANCH:     shaped = manch;
      ENV_MANCH_SC:  shaped = manch & sc;
      ENV_BPSK:      shaped = sc ^ ~bit_in;
      ENV_RZ_SECOND: shaped = bit_in & (quarter >= 2'h2);
      ENV_RZ_FIRST:  shaped = bit_in & (quarter < 2'h2);
      default:       shaped = 1'b0;
    endcase
    if (mode[MOD_MILLER]) begin
      // a zero after a one carries no pause; on a bit's first cycle the
      // previous bit is still held in last, prev catches up a cycle later
      pulse = bit_in ? (quarter == 2'h2) :
              (!(bit_start ? r.last : r.prev) && quarter == 2'h0);
    end else begin
      case (ptype)
        PULSE_START:   pulse = bit_in && quarter == 2'h0;
        PULSE_HALF:    pulse = bit_in && quarter == 2'h2;
        PULSE_QUARTER: pulse = bit_in && quarter == 2'h3;
        default:       pulse = 1'b0;
      endcase
    end
    if (pulse) begin
      shaped = 1'b0;
    end
    next_r.out = active & (shaped ^ mode[MOD_INVERT]);
    if (!active) begin
      next_r.prev = 1'b0;
      next_r.last = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign env_out = r.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_direct;
    active && env == ENV_DIRECT && !mode[MOD_MILLER] && ptype == PULSE_NONE
      && !mode[MOD_INVERT] |=> env_out == $past(bit_in);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct envelope does not follow the bit");

  property p_invert;
    active && env == ENV_RZ_FIRST && !mode[MOD_MILLER]
      && ptype == PULSE_NONE && mode[MOD_INVERT] && quarter >= 2'h2
      |=> env_out;
  endproperty
  a_invert: assert property (p_invert)
    else $error("inverted envelope not high in a gap");

  property p_rz_second;
    active && env == ENV_RZ_SECOND && !mode[MOD_INVERT] && quarter < 2'h2
      |=> !env_out;
  endproperty
  a_rz_second: assert property (p_rz_second)
    else $error("second-half pulse seen in first half");

  property p_miller;
    active && mode[MOD_MILLER] && !mode[MOD_INVERT] && env == ENV_DIRECT
      && bit_in && quarter == 2'h2 |=> !env_out;
  endproperty
  a_miller: assert property (p_miller)
    else $error("modified miller pause missing for a one");

  property p_pulse_q3;
    active && !mode[MOD_MILLER] && ptype == PULSE_QUARTER
      && !mode[MOD_INVERT] && quarter == 2'h3 && bit_in |=> !env_out;
  endproperty
  a_pulse_q3: assert property (p_pulse_q3)
    else $error("third-quarter pulse missing");
endmodule // tdes_shaper
